// file: design/ipff_pkg.sv
// Purpose: shared constants, types and register map of the pin FIFO block
// Assumes: one clock domain, APB register access with 32-bit data
// Notes: storage depth and threshold range are fixed by the pin FIFO cell
package ipff_pkg;
    // storage geometry
    localparam int IPFF_DEPTH = 64;
    localparam int IPFF_PTR_W = 6;
    localparam int IPFF_LVL_W = 7;
    localparam int IPFF_THR_W = 6;
    localparam int IPFF_WIDTH_MAX = 499;
    localparam int IPFF_CLUSTER_PINS = 2;
    localparam int IPFF_CLUSTERS_MAX = 13;
    localparam int IPFF_CTRL_PER_EDGE = 2;
    localparam logic [IPFF_LVL_W-1:0] IPFF_LVL_FULL = 7'h40;
    localparam logic [IPFF_LVL_W-1:0] IPFF_LVL_ZERO = 7'h00;
    localparam logic [IPFF_PTR_W-1:0] IPFF_PTR_ZERO = 6'h00;
    localparam logic [IPFF_PTR_W-1:0] IPFF_PTR_ONE = 6'h01;
    localparam logic [IPFF_THR_W-1:0] IPFF_THR_RST = 6'h01;
    localparam logic [IPFF_THR_W-1:0] IPFF_THR_ZERO = 6'h00;
    // register map, byte addresses
    localparam int IPFF_AW = 8;
    localparam logic [IPFF_AW-1:0] IPFF_OFS_CTRL = 8'h00;
    localparam logic [IPFF_AW-1:0] IPFF_OFS_THRESH = 8'h04;
    localparam logic [IPFF_AW-1:0] IPFF_OFS_STATUS = 8'h08;
    localparam logic [IPFF_AW-1:0] IPFF_OFS_INT_STAT = 8'h0C;
    localparam logic [IPFF_AW-1:0] IPFF_OFS_INT_MASK = 8'h10;
    // field positions
    localparam int IPFF_TH_LOW_LSB = 0;
    localparam int IPFF_TH_HIGH_LSB = 8;
    localparam int IPFF_ST_LVL_LSB = 16;
    // interrupt event bits
    localparam int IPFF_EV_N = 6;
    localparam int IPFF_EV_OVERFLOW = 0;
    localparam int IPFF_EV_UNDERFLOW = 1;
    localparam int IPFF_EV_FULL = 2;
    localparam int IPFF_EV_EMPTY = 3;
    localparam int IPFF_EV_ALMOST_FULL_FLAG = 4;
    localparam int IPFF_EV_ALMOST_EMPTY_FLAG = 5;
    localparam logic [IPFF_EV_N-1:0] IPFF_EV_RST = 6'h00;

    typedef enum logic [1:0] {
        IPFF_MODE_BYPASS = 2'b00,
        IPFF_MODE_BLOCK = 2'b01,
        IPFF_MODE_SINGLE = 2'b10
    } ipff_mode_t;

    typedef struct packed {
        logic almost_full;
        logic almost_empty;
        logic full;
        logic empty;
    } ipff_flags_t;

    localparam ipff_flags_t IPFF_FLAGS_CLEAR = '{1'b0, 1'b1, 1'b0, 1'b1};

    typedef struct packed {
        logic [IPFF_THR_W-1:0] high;
        logic [IPFF_THR_W-1:0] low;
    } ipff_thresh_t;
endpackage

// file: design/ipff_top.sv
// Purpose: one pin FIFO group with its block controller, flags and APB registers
// Assumes: read and write sides share mclk; enables and clear are synchronous to it
// Notes: flags and read data are registered; threshold value 0 is served as 1
//
// Functional notes
// R1 - each pin lane has 64 one-bit entries buffering pin data
// R2 - per lane: bypass, part of a grouped block, or single-bit FIFO
// R3 - lanes pair into clusters of two; up to 13 clusters share a controller
// R4 - two independent controllers per tile edge, each owning its own group
// R5 - writes blocked when full, reads blocked when empty, whatever the enables
// R6 - read enable low at the edge outputs word at read pointer, then advances
// R7 - write enable low at the edge stores data at write pointer, then advances
// R8 - clear low zeroes read data and returns both pointers to location 0
// R9 - empty flag set when no data held, timed by the read clock
// R10 - full flag set at maximum entries, timed by the write clock
// R11 - almost-empty set when level at or below threshold 1 to 63
// R12 - almost-full set when level at or above threshold 1 to 63
// R13 - both thresholds default to 1
// R14 - bank width 1 to 499 bits, default 1
// R15 - a soft controller uses the same controls and gives identical flags
// R16 - controller serves clocks up to 350 MHz
// R17 - a blocked access changes neither data, pointers nor level
// R18 - after clear, empty and almost-empty set, full and almost-full clear
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ipff_top
    import ipff_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IPFF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // user data side
    input wire logic clear_n,
    input wire logic write_en_n,
    input wire logic [WIDTH-1:0] write_data_in,
    input wire logic read_en_n,
    output logic [WIDTH-1:0] read_data,
    // flags
    output logic empty_flag,
    output logic full_flag,
    output logic almost_empty_flag,
    output logic almost_full_flag,
    output logic irq
);
    // R14 R3 R4: one instance is one controller; wider banks join several instances
    generate
        if (WIDTH < 1 || WIDTH > IPFF_WIDTH_MAX) begin : g_bad_width
            $error("ipff_top: WIDTH out of range");
        end
    endgenerate

    // a zero threshold is outside the legal range; serve it as the minimum
    function automatic logic [IPFF_THR_W-1:0] thr_fix(input logic [IPFF_THR_W-1:0] v);
        thr_fix = (v == IPFF_THR_ZERO) ? IPFF_THR_RST : v;
    endfunction

    // configuration and interrupt registers
    ipff_mode_t mode;
    ipff_thresh_t thresh;
    logic [IPFF_EV_N-1:0] int_stat;
    logic [IPFF_EV_N-1:0] int_mask;

    // storage and pointers
    logic [WIDTH-1:0] mem [IPFF_DEPTH];
    logic [IPFF_PTR_W-1:0] wptr;
    logic [IPFF_PTR_W-1:0] rptr;
    logic [IPFF_LVL_W-1:0] level;
    ipff_flags_t flags;

    // datapath decode
    wire logic buffered = (mode != IPFF_MODE_BYPASS);
    wire logic wr_req = buffered && !write_en_n;
    wire logic rd_req = buffered && !read_en_n;
    wire logic wr_ok = wr_req && !flags.full; // R5 R17
    wire logic rd_ok = rd_req && !flags.empty; // R5 R17
    wire logic [IPFF_LVL_W-1:0] wr_inc = {{(IPFF_LVL_W-1){1'b0}}, wr_ok};
    wire logic [IPFF_LVL_W-1:0] rd_dec = {{(IPFF_LVL_W-1){1'b0}}, rd_ok};
    wire logic [IPFF_LVL_W-1:0] next_level = level + wr_inc - rd_dec;
    wire logic [IPFF_LVL_W-1:0] low_level_threshold = {1'b0, thr_fix(thresh.low)};
    wire logic [IPFF_LVL_W-1:0] high_level_threshold = {1'b0, thr_fix(thresh.high)};

    // flags from the next level so they match the stored level after the edge;
    // one add, one subtract and four compares keep the path short enough for 350 MHz (R16)
    ipff_flags_t next_flags;
    assign next_flags.empty = (next_level == IPFF_LVL_ZERO); // R9 R15
    assign next_flags.full = (next_level == IPFF_LVL_FULL); // R10 R15
    assign next_flags.almost_empty = (next_level <= low_level_threshold); // R11
    assign next_flags.almost_full = (next_level >= high_level_threshold); // R12

    // read word: single mode buffers lane 0 only, the other lanes pass straight
    wire logic [WIDTH-1:0] head = mem[rptr];
    logic [WIDTH-1:0] next_read_data;
    always_comb begin
        next_read_data = read_data;
        unique case (mode)
            IPFF_MODE_BYPASS: begin
                next_read_data = write_data_in; // R2
            end
            IPFF_MODE_BLOCK: begin
                if (rd_ok) begin
                    next_read_data = head; // R6
                end
            end
            IPFF_MODE_SINGLE: begin
                next_read_data = write_data_in; // R2
                next_read_data[0] = rd_ok ? head[0] : read_data[0]; // R6
            end
            default: begin
                next_read_data = write_data_in;
            end
        endcase
    end

    // storage has no reset, so it maps to plain memory
    always_ff @(posedge mclk) begin
        if (wr_ok) begin
            mem[wptr] <= write_data_in; // R7 R1
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !clear_n) begin
            wptr <= IPFF_PTR_ZERO; // R8
            rptr <= IPFF_PTR_ZERO; // R8
            level <= IPFF_LVL_ZERO;
            flags <= IPFF_FLAGS_CLEAR; // R18
            read_data <= '0; // R8
        end else begin
            wptr <= wr_ok ? wptr + IPFF_PTR_ONE : wptr; // R7
            rptr <= rd_ok ? rptr + IPFF_PTR_ONE : rptr; // R6
            level <= next_level;
            flags <= next_flags;
            read_data <= next_read_data;
        end
    end

    always_comb begin
        empty_flag = flags.empty;
        full_flag = flags.full;
        almost_empty_flag = flags.almost_empty;
        almost_full_flag = flags.almost_full;
    end

    // events: blocked accesses and rising flag edges
    logic [IPFF_EV_N-1:0] events;
    always_comb begin
        events = IPFF_EV_RST;
        events[IPFF_EV_OVERFLOW] = wr_req && flags.full && clear_n;
        events[IPFF_EV_UNDERFLOW] = rd_req && flags.empty && clear_n;
        events[IPFF_EV_FULL] = next_flags.full && !flags.full && clear_n;
        events[IPFF_EV_EMPTY] = next_flags.empty && !flags.empty && clear_n;
        events[IPFF_EV_ALMOST_FULL_FLAG] = next_flags.almost_full && !flags.almost_full && clear_n;
        events[IPFF_EV_ALMOST_EMPTY_FLAG] = next_flags.almost_empty && !flags.almost_empty && clear_n;
    end

    // apb decode; one wait state so read data and error come from flops
    wire logic access = psel && penable;
    wire logic done = access && pready;
    wire logic wr_fire = done && pwrite;
    wire logic hit_ctrl = (paddr == IPFF_OFS_CTRL);
    wire logic hit_thresh = (paddr == IPFF_OFS_THRESH);
    wire logic hit_status = (paddr == IPFF_OFS_STATUS);
    wire logic hit_stat = (paddr == IPFF_OFS_INT_STAT);
    wire logic hit_mask = (paddr == IPFF_OFS_INT_MASK);
    wire logic mapped = hit_ctrl || hit_thresh || hit_status || hit_stat || hit_mask;
    wire logic [1:0] wmode = pwdata[1:0];
    wire logic mode_legal = (wmode == IPFF_MODE_BYPASS) || (wmode == IPFF_MODE_BLOCK)
        || (wmode == IPFF_MODE_SINGLE);
    wire logic [IPFF_EV_N-1:0] w1c = (wr_fire && hit_stat) ? pwdata[IPFF_EV_N-1:0] : IPFF_EV_RST;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[1:0] = mode;
        end
        if (hit_thresh) begin
            rd_mux[IPFF_TH_LOW_LSB +: IPFF_THR_W] = thresh.low;
            rd_mux[IPFF_TH_HIGH_LSB +: IPFF_THR_W] = thresh.high;
        end
        if (hit_status) begin
            rd_mux[3:0] = flags;
            rd_mux[IPFF_ST_LVL_LSB +: IPFF_LVL_W] = level;
        end
        if (hit_stat) begin
            rd_mux[IPFF_EV_N-1:0] = int_stat;
        end
        if (hit_mask) begin
            rd_mux[IPFF_EV_N-1:0] = int_mask;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata <= (access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode <= IPFF_MODE_BLOCK;
            thresh <= '{IPFF_THR_RST, IPFF_THR_RST}; // R13
            int_mask <= IPFF_EV_RST;
        end else if (wr_fire) begin
            if (hit_ctrl && mode_legal) begin
                mode <= ipff_mode_t'(wmode);
            end
            if (hit_thresh) begin
                thresh.low <= pwdata[IPFF_TH_LOW_LSB +: IPFF_THR_W]; // R11
                thresh.high <= pwdata[IPFF_TH_HIGH_LSB +: IPFF_THR_W]; // R12
            end
            if (hit_mask) begin
                int_mask <= pwdata[IPFF_EV_N-1:0];
            end
        end
    end

    // a new event in the clearing cycle survives the write of one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_stat <= IPFF_EV_RST;
            irq <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~w1c) | events;
            irq <= |(int_stat & int_mask);
        end
    end
endmodule
`default_nettype wire

// file: dv/ipff_checker.sv
// Purpose: port-level temporal checks of the pin FIFO block
// Assumes: one clock, rst_n synchronous and active low
// Notes: flag checks expect idle enables while the lane is bypassed
`timescale 1ns/1ns
`default_nettype none
module ipff_checker
    import ipff_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [IPFF_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // data side
    input wire logic clear_n,
    input wire logic write_en_n,
    input wire logic [WIDTH-1:0] write_data_in,
    input wire logic read_en_n,
    input wire logic [WIDTH-1:0] read_data,
    // flags
    input wire logic empty_flag,
    input wire logic full_flag,
    input wire logic almost_empty_flag,
    input wire logic almost_full_flag,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_full_blocks_wr: assert property (full_flag && !write_en_n && read_en_n && clear_n
        |=> full_flag) else $error("write taken while full");
    a_empty_blocks_rd: assert property (empty_flag && !read_en_n && write_en_n && clear_n
        |=> empty_flag) else $error("read taken while empty");
    a_write_fills: assert property (empty_flag && !write_en_n && read_en_n && clear_n
        |=> !empty_flag) else $error("write into empty store lost");
    a_read_drains: assert property (full_flag && !read_en_n && write_en_n && clear_n
        |=> !full_flag) else $error("read from full store lost");
    a_clear_state: assert property (!clear_n |=> empty_flag && almost_empty_flag &&
        !full_flag && !almost_full_flag && read_data == '0) else $error("clear state wrong");
    a_flag_excl: assert property (!(empty_flag && full_flag))
        else $error("empty and full together");
    a_ae_on_empty: assert property (empty_flag |-> almost_empty_flag)
        else $error("almost empty missing");
    a_af_on_full: assert property (full_flag |-> almost_full_flag)
        else $error("almost full missing");
    a_ready_second: assert property ($rose(psel && penable) |=> pready ##1 !pready)
        else $error("ready timing wrong");
    c_full: cover property (full_flag && !write_en_n);
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
endmodule
bind ipff_top ipff_checker #(.WIDTH(WIDTH)) chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clear_n(clear_n), .write_en_n(write_en_n),
    .write_data_in(write_data_in), .read_en_n(read_en_n), .read_data(read_data),
    .empty_flag(empty_flag), .full_flag(full_flag), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag), .irq(irq));
`default_nettype wire

// file: dv/ipff_core_model.sv
// Purpose: core logic that pushes and pops words through the pin FIFO
// Assumes: one request per call, held for exactly one rising edge
// Notes: released data shows the inverse so stale words never match
`timescale 1ns/1ns
`default_nettype none
module ipff_core_model #(
    parameter int W = 8
) (
    // clock
    input wire logic mclk,
    // requests
    output logic write_en_n = 1'b1,
    output logic read_en_n = 1'b1,
    output logic [W-1:0] write_data_in = '0
);
    task automatic op(input logic w, input logic r, input logic [W-1:0] d);
        @(posedge mclk);
        write_en_n <= !w;
        read_en_n <= !r;
        write_data_in <= d;
        @(posedge mclk);
        write_en_n <= 1'b1;
        read_en_n <= 1'b1;
        write_data_in <= ~d;
    endtask
endmodule
`default_nettype wire

// file: dv/test_io_pin_fifo_with_flags.sv
// Purpose: self-checking bench of the pin FIFO block
// Assumes: block mode after reset, thresholds 1/1
// Notes: words are checked 1 ns after the edge that takes them
`timescale 1ns/1ns
`default_nettype none
module test_io_pin_fifo_with_flags;
    import ipff_pkg::*;
    localparam int W = 8;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic clear_n = 1'b1, pready, pslverr, perr, irq, ef, ff, aef, aff, write_en_n, read_en_n;
    logic [IPFF_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [W-1:0] write_data_in, read_data;
    ipff_flags_t fl;
    int err_count = 0, n_tests = 0;
    assign fl = {aff, aef, ff, ef};
    always #2 mclk = ~mclk;
    ipff_core_model #(.W(W)) core_u (.mclk(mclk), .write_en_n(write_en_n),
        .read_en_n(read_en_n), .write_data_in(write_data_in));
    ipff_top #(.WIDTH(W)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clear_n(clear_n), .write_en_n(write_en_n),
        .write_data_in(write_data_in), .read_en_n(read_en_n), .read_data(read_data),
        .empty_flag(ef), .full_flag(ff), .almost_empty_flag(aef), .almost_full_flag(aff),
        .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [IPFF_AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_reset();
        chk(32'(fl), 32'(IPFF_FLAGS_CLEAR));
        apb(1'b0, IPFF_OFS_THRESH, 0);
        chk(rd, 32'h0000_0101);
        apb(1'b0, 8'h40, 0);
        chk({rd[30:0], perr}, 32'h0000_0001);
    endtask
    task automatic t_fill();
        for (int i = 0; i < 64; i++) begin
            core_u.op(1'b1, 1'b0, W'(i) ^ 8'hA5);
            #1 chk(32'(ff), 32'(i == 63));
        end
        core_u.op(1'b1, 1'b0, 8'h00);
        apb(1'b0, IPFF_OFS_STATUS, 0);
        chk(rd, 32'h0040_000A);
        apb(1'b0, IPFF_OFS_INT_STAT, 0);
        chk(rd, 32'h0000_0015);
        apb(1'b1, IPFF_OFS_INT_MASK, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        #1 chk(32'(irq), 32'h1);
        apb(1'b1, IPFF_OFS_INT_STAT, 32'h0000_0015);
        repeat (2) @(posedge mclk);
        #1 chk(32'(irq), 32'h0);
    endtask
    task automatic t_drain();
        for (int i = 0; i < 64; i++) begin
            core_u.op(1'b0, 1'b1, 8'h00);
            #1 chk(32'(read_data), 32'(W'(i) ^ 8'hA5));
        end
        core_u.op(1'b0, 1'b1, 8'h00);
        #1 chk({read_data, 24'(fl)}, {8'h9A, 24'h5});
        apb(1'b0, IPFF_OFS_INT_STAT, 0);
        chk(rd, 32'h0000_002A);
        apb(1'b1, IPFF_OFS_INT_STAT, 32'h0000_003F);
    endtask
    task automatic t_thresh_clear();
        apb(1'b1, IPFF_OFS_THRESH, 32'h0000_0503);
        for (int l = 1; l <= 5; l++) begin
            core_u.op(1'b1, 1'b0, 8'h11);
            #1 chk(32'(fl), {28'h0, l >= 5, l <= 3, 2'b00});
        end
        @(posedge mclk);
        clear_n <= 1'b0;
        @(posedge mclk);
        clear_n <= 1'b1;
        #1 chk({read_data, 24'(fl)}, {8'h00, 24'(IPFF_FLAGS_CLEAR)});
        core_u.op(1'b1, 1'b0, 8'h5A);
        core_u.op(1'b0, 1'b1, 8'h00);
        #1 chk(32'(read_data), 32'h5A);
    endtask
    task automatic t_bypass();
        apb(1'b1, IPFF_OFS_CTRL, 32'h0);
        core_u.op(1'b0, 1'b0, 8'hC3);
        #1 chk({read_data, 24'(fl)}, {8'hC3, 24'h5});
        apb(1'b1, IPFF_OFS_CTRL, 32'h2);
        core_u.op(1'b1, 1'b0, 8'hF0);
        core_u.op(1'b0, 1'b1, 8'h0F);
        #1 chk(32'(read_data), 32'h0000_000E);
        apb(1'b1, IPFF_OFS_CTRL, 32'h1);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 t_reset();
        t_fill();
        t_drain();
        t_thresh_clear();
        t_bypass();
        tally_and_finish();
    end
    initial begin
        #40000;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
